// ==== src/gp1_regs.vh ====
`ifndef GP1_REGS_VH
`define GP1_REGS_VH

// register indices, byte address is four times the index
`define GP1_IDX_LATCH      16'hFE44
`define GP1_IDX_DIR        16'hFE45
`define GP1_IDX_FUNC       16'hFE46
`define GP1_IDX_TEST       16'hFE47
`define GP1_IDX_LATCH_RAW  16'hFE4C
`define GP1_IDX_LATCH_OP   16'hFE4D

// bus geometry
`define GP1_ADR_HI         17
`define GP1_ADR_LO         2
`define GP1_DW             32
`define GP1_PW             8

// reset values
`define GP1_RST_BYTE       8'h00
`define GP1_RST_TEST       3'h0

// test register fields and read-as-one bits
`define GP1_TST_FIX_HI     7
`define GP1_TST_RT         2
`define GP1_TST_FIX_LO     0
`define GP1_TST_ONES       8'h7A

// latch operation field
`define GP1_OP_CODE_HI     10
`define GP1_OP_CODE_LO     8
`define GP1_OP_BIT_HI      2
`define GP1_OP_BIT_LO      0
`define GP1_OP_NOT         3'h0
`define GP1_OP_CLR         3'h1
`define GP1_OP_SET         3'h2
`define GP1_OP_INC         3'h3
`define GP1_OP_DEC         3'h4

// zero flag position in raw latch read
`define GP1_RAW_ZERO       8

// multiplexed pin positions
`define GP1_PIN_HPW        7
`define GP1_PIN_LPW        6
`define GP1_PIN_S1CLK      5
`define GP1_PIN_S1IN       4
`define GP1_PIN_S1OUT      3
`define GP1_PIN_S0CLK      2
`define GP1_PIN_S0IN       1
`define GP1_PIN_S0OUT      0

`endif

// ==== src/gp1_port.v ====
// Our own choice: the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none

`include "gp1_regs.vh"

////////////////////////////////////////////////////////////////////////////////
// Behaviour
// (RL1) plain latch read returns synchronised pin levels
// (RL2) bit and count operations use stored latch
// (RL3) pin levels readable in any direction
// (RL4) direction bit one output, zero input
// (RL5) pull-up only for input with latch one
// (RL6) output latch zero low, one high/released
// (RL7) open-drain pins release every high level
// (RL8) function clear drives latch value only
// (RL9) pin7 function: (high pulse AND buzzer) XOR latch
// (RL10) pin6 function: low pulse XOR latch
// (RL11) pin5 function: second serial clock OR latch
// (RL12) pin4 function: second serial data OR latch
// (RL13) second serial input from pin4 while active
// (RL14) pin3 function: second serial data OR latch
// (RL15) pin2 function: first serial clock OR latch
// (RL16) pin1 function: first serial data OR latch
// (RL17) first serial input from pin1 while active
// (RL18) pin0 function: first serial data OR latch
// (RL19) software writes zero to reserved test bits
// (RL20) latch, direction, function reset to zero
// (RL21) standby freezes pin drive and pull-ups
// (RL22) pin inputs pass two-stage synchroniser
module gp1_port #(
	parameter [7:0] OPEN_DRAIN = 8'h00
) (
	input  wire        clk_i,
	input  wire        rst_b_i,
	input  wire        cyc_i,
	input  wire        stb_i,
	input  wire        we_i,
	input  wire [17:2] adr_i,
	input  wire [3:0]  sel_i,
	input  wire [31:0] dat_i,
	output reg  [31:0] dat_o,
	output reg         ack_o,
	input  wire [7:0]  pin_i,
	output reg  [7:0]  pin_o,
	output reg  [7:0]  pin_oe_b_o,
	output reg  [7:0]  pull_up_o,
	input  wire        standby_i,
	input  wire        timer_high_pulse_i,
	input  wire        timer_low_pulse_i,
	input  wire        buzzer_i,
	input  wire        ser0_clk_i,
	input  wire        ser0_data_i,
	input  wire        ser0_active_i,
	input  wire        ser1_clk_i,
	input  wire        ser1_data_i,
	input  wire        ser1_active_i,
	output reg         ser0_data_in_o,
	output reg         ser1_data_in_o,
	output reg         realtime_counter_output_ctl_o
);

	////////////////////////////////////////////////////////////////////////////
	// registers and wires

	reg  [7:0]  port_output_latch;
	reg  [7:0]  port_direction;
	reg  [7:0]  port_function_select;
	reg         test_fix_hi;
	reg         test_fix_lo;
	reg  [7:0]  pin_meta;
	reg  [7:0]  pin_sync;
	reg  [7:0]  next_latch;
	reg  [31:0] next_dat;

	wire [7:0]  func_level;
	wire [7:0]  next_level;
	wire [7:0]  next_pin;
	wire [7:0]  next_drive;
	wire [7:0]  next_pull;
	wire [2:0]  op_code;
	wire [2:0]  op_bit;
	wire        bus_req;
	wire        rd_req;
	wire        wr_low;
	wire        wr_latch;
	wire        wr_op;
	wire        wr_dir;
	wire        wr_func;
	wire        wr_test;

	////////////////////////////////////////////////////////////////////////////
	// address decode

	function is_reg;
		input [15:0] adr;
		input [15:0] idx;
		begin
			is_reg = (adr == idx);
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// bus strobes

	// a request is answered once, then ack blocks a repeat
	assign bus_req  = cyc_i & stb_i & ~ack_o;
	assign rd_req   = bus_req & ~we_i;
	assign wr_low   = bus_req & we_i & sel_i[0];
	assign wr_latch = wr_low & is_reg(adr_i, `GP1_IDX_LATCH);
	assign wr_op    = wr_low & is_reg(adr_i, `GP1_IDX_LATCH_OP);
	assign wr_dir   = wr_low & is_reg(adr_i, `GP1_IDX_DIR);
	assign wr_func  = wr_low & is_reg(adr_i, `GP1_IDX_FUNC);
	assign wr_test  = wr_low & is_reg(adr_i, `GP1_IDX_TEST);

	assign op_code  = dat_i[`GP1_OP_CODE_HI:`GP1_OP_CODE_LO];
	assign op_bit   = dat_i[`GP1_OP_BIT_HI:`GP1_OP_BIT_LO];

	////////////////////////////////////////////////////////////////////////////
	// pin synchroniser

	// first stage feeds only the second stage
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_meta <= `GP1_RST_BYTE;
		end else begin
			pin_meta <= pin_i; // [RL22]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_sync <= `GP1_RST_BYTE;
		end else begin
			pin_sync <= pin_meta; // [RL22]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// latch operations

	// op register emulates read-modify-write on the latch
	always @* begin
		next_latch = port_output_latch;
		case (op_code)
			`GP1_OP_NOT: begin
				next_latch[op_bit] = ~port_output_latch[op_bit]; // [RL2]
			end
			`GP1_OP_CLR: begin
				next_latch[op_bit] = 1'b0; // [RL2]
			end
			`GP1_OP_SET: begin
				next_latch[op_bit] = 1'b1; // [RL2]
			end
			`GP1_OP_INC: begin
				next_latch = port_output_latch + 8'h01; // [RL2]
			end
			`GP1_OP_DEC: begin
				next_latch = port_output_latch - 8'h01; // [RL2]
			end
			default: begin
				next_latch = port_output_latch;
			end
		endcase
	end

	////////////////////////////////////////////////////////////////////////////
	// register writes

	// registers stay writable in standby
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			port_output_latch <= `GP1_RST_BYTE; // [RL20]
		end else if (wr_latch) begin
			port_output_latch <= dat_i[7:0];
		end else if (wr_op) begin
			port_output_latch <= next_latch; // [RL2]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			port_direction <= `GP1_RST_BYTE; // [RL20]
		end else if (wr_dir) begin
			port_direction <= dat_i[7:0]; // [RL4]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			port_function_select <= `GP1_RST_BYTE; // [RL20]
		end else if (wr_func) begin
			port_function_select <= dat_i[7:0];
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			test_fix_hi <= 1'b0;
			test_fix_lo <= 1'b0;
		end else if (wr_test) begin
			test_fix_hi <= dat_i[`GP1_TST_FIX_HI]; // [RL19]
			test_fix_lo <= dat_i[`GP1_TST_FIX_LO]; // [RL19]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			realtime_counter_output_ctl_o <= 1'b0;
		end else if (wr_test) begin
			realtime_counter_output_ctl_o <= dat_i[`GP1_TST_RT];
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// read mux

	always @* begin
		next_dat = {`GP1_DW{1'b0}};
		case (adr_i)
			`GP1_IDX_LATCH: begin
				next_dat[7:0] = pin_sync; // [RL1] [RL3]
			end
			`GP1_IDX_LATCH_RAW: begin
				next_dat[7:0]           = port_output_latch; // [RL2]
				next_dat[`GP1_RAW_ZERO] = (port_output_latch == `GP1_RST_BYTE);
			end
			`GP1_IDX_DIR: begin
				next_dat[7:0] = port_direction;
			end
			`GP1_IDX_FUNC: begin
				next_dat[7:0] = port_function_select;
			end
			`GP1_IDX_TEST: begin
				next_dat[7:0]             = `GP1_TST_ONES;
				next_dat[`GP1_TST_FIX_HI] = test_fix_hi;
				next_dat[`GP1_TST_RT]     = realtime_counter_output_ctl_o;
				next_dat[`GP1_TST_FIX_LO] = test_fix_lo;
			end
			// unmapped indices read zero
			default: begin
				next_dat = {`GP1_DW{1'b0}};
			end
		endcase
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ack_o <= 1'b0;
		end else begin
			ack_o <= bus_req;
		end
	end

	// read data holds until the next read
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			dat_o <= {`GP1_DW{1'b0}};
		end else if (rd_req) begin
			dat_o <= next_dat;
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// function multiplexer

	// open-drain masking is applied at the pin drive
	function func_pick;
		input integer idx;
		input         latch_bit;
		input         hpw_buz;
		input         lpw;
		input         s1_clk;
		input         s1_dat;
		input         s0_clk;
		input         s0_dat;
		begin
			case (idx)
				`GP1_PIN_HPW: begin
					func_pick = hpw_buz ^ latch_bit; // [RL9]
				end
				`GP1_PIN_LPW: begin
					func_pick = lpw ^ latch_bit; // [RL10]
				end
				`GP1_PIN_S1CLK: begin
					func_pick = s1_clk | latch_bit; // [RL11]
				end
				`GP1_PIN_S1IN: begin
					func_pick = s1_dat | latch_bit; // [RL12]
				end
				`GP1_PIN_S1OUT: begin
					func_pick = s1_dat | latch_bit; // [RL14]
				end
				`GP1_PIN_S0CLK: begin
					func_pick = s0_clk | latch_bit; // [RL15]
				end
				`GP1_PIN_S0IN: begin
					func_pick = s0_dat | latch_bit; // [RL16]
				end
				`GP1_PIN_S0OUT: begin
					func_pick = s0_dat | latch_bit; // [RL18]
				end
				default: begin
					func_pick = latch_bit;
				end
			endcase
		end
	endfunction

	////////////////////////////////////////////////////////////////////////////
	// per-pin drive

	genvar n;
	generate
		for (n = 0; n < `GP1_PW; n = n + 1) begin : g_pin
			assign func_level[n] = func_pick(n, port_output_latch[n],
				timer_high_pulse_i & buzzer_i, timer_low_pulse_i, ser1_clk_i,
				ser1_data_i, ser0_clk_i, ser0_data_i);
			assign next_level[n] = port_function_select[n] ? func_level[n]
				: port_output_latch[n]; // [RL8]
			assign next_pin[n]   = next_level[n]
				& ~OPEN_DRAIN[n]; // [RL6] [RL7]
			assign next_drive[n] = port_direction[n]
				& ~(OPEN_DRAIN[n] & next_level[n]); // [RL4] [RL6] [RL7]
			assign next_pull[n]  = ~port_direction[n]
				& port_output_latch[n]; // [RL5]
		end
	endgenerate

	// standby holds drive and pull-ups as at entry
	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_o <= `GP1_RST_BYTE;
		end else if (!standby_i) begin // [RL21]
			pin_o <= next_pin; // [RL6] [RL7]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pin_oe_b_o <= ~`GP1_RST_BYTE;
		end else if (!standby_i) begin // [RL21]
			pin_oe_b_o <= ~next_drive; // [RL4]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			pull_up_o <= `GP1_RST_BYTE;
		end else if (!standby_i) begin // [RL21]
			pull_up_o <= next_pull; // [RL5]
		end
	end

	////////////////////////////////////////////////////////////////////////////
	// serial inputs, held while the unit is idle

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ser0_data_in_o <= 1'b0;
		end else if (ser0_active_i) begin
			ser0_data_in_o <= pin_sync[`GP1_PIN_S0IN]; // [RL17]
		end
	end

	always @(posedge clk_i) begin
		if (!rst_b_i) begin
			ser1_data_in_o <= 1'b0;
		end else if (ser1_active_i) begin
			ser1_data_in_o <= pin_sync[`GP1_PIN_S1IN]; // [RL13]
		end
	end

endmodule // gp1_port

`default_nettype wire

// ==== verif/gp1_port_asserts.sv ====
`timescale 1ns/1ps
`default_nettype none
module gp1_chk #(parameter [7:0] OPEN_DRAIN = 8'h00) (
	input wire logic       clk_i,
	input wire logic       rst_b_i,
	input wire logic       cyc_i,
	input wire logic       stb_i,
	input wire logic       ack_o,
	input wire logic [7:0] pin_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_b_o,
	input wire logic [7:0] pull_up_o,
	input wire logic       standby_i,
	input wire logic       ser0_active_i,
	input wire logic       ser1_active_i,
	input wire logic       ser0_data_in_o,
	input wire logic       ser1_data_in_o
);
	default clocking @(posedge clk_i); endclocking
	default disable iff (!rst_b_i);
	ack_after_req_a: assert property (cyc_i && stb_i && !ack_o |=> ack_o)
		else $error("request not acknowledged");
	ack_pulse_a: assert property (ack_o |-> $past(cyc_i && stb_i) ##1 !ack_o)
		else $error("ack not a single pulse");
	reset_state_a: assert property ($past(!rst_b_i) |-> pin_oe_b_o == 8'hFF && pull_up_o == 8'h00)
		else $error("pins not in reset state");
	pull_input_a: assert property ((pull_up_o & ~pin_oe_b_o) == 8'h00)
		else $error("pull-up on a driven pin");
	od_release_a: assert property ((pin_o & ~pin_oe_b_o & OPEN_DRAIN) == 8'h00)
		else $error("open-drain pin driven high");
	standby_hold_a: assert property ($past(standby_i) |-> $stable(pin_o) && $stable(pin_oe_b_o) && $stable(pull_up_o))
		else $error("pins changed in standby");
	ser0_sync_a: assert property ($past(ser0_active_i) |-> ser0_data_in_o == $past(pin_i[1], 3))
		else $error("first serial input wrong");
	ser1_sync_a: assert property ($past(ser1_active_i) |-> ser1_data_in_o == $past(pin_i[4], 3))
		else $error("second serial input wrong");
endmodule // gp1_chk
bind gp1_port gp1_chk #(.OPEN_DRAIN(OPEN_DRAIN)) gp1_chk_inst (.clk_i(clk_i), .rst_b_i(rst_b_i),
	.cyc_i(cyc_i), .stb_i(stb_i), .ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o),
	.pin_oe_b_o(pin_oe_b_o), .pull_up_o(pull_up_o), .standby_i(standby_i),
	.ser0_active_i(ser0_active_i), .ser1_active_i(ser1_active_i),
	.ser0_data_in_o(ser0_data_in_o), .ser1_data_in_o(ser1_data_in_o));
`default_nettype wire

// ==== verif/gp1_board.sv ====
`timescale 1ns/1ps
`default_nettype none
module gp1_board (
	input wire logic       clk_i,
	input wire logic [7:0] pin_o,
	input wire logic [7:0] pin_oe_b_o,
	input wire logic [7:0] pull_up_o,
	input wire logic [7:0] ext_en_i,
	input wire logic [7:0] ext_i,
	output wire logic [7:0] lvl_o
);
	logic [7:0] flip = 8'h00;
	always @(posedge clk_i) flip <= ~flip;
	// device drive, else board driver, else pull-up, else floating
	assign lvl_o = (~pin_oe_b_o & pin_o) | (pin_oe_b_o & ext_en_i & ext_i)
		| (pin_oe_b_o & ~ext_en_i & (pull_up_o | flip));
endmodule // gp1_board
`default_nettype wire

// ==== verif/tb_gp1_port.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "gp1_regs.vh"
module tb_gp1_port;
	localparam [7:0] OD = 8'h81;
	logic        clk_i = 0, rst_b_i = 0, cyc = 0, stb = 0, we = 0, sb = 0;
	logic [15:0] adr = 0;
	logic [31:0] dat = 0, dat_o, rs = 32'hB7B0;
	logic [8:0]  fi = 0, x = 0;
	logic [7:0]  pin_i, pin_o, oe_b, pu, ext = 0, exten = 0, l = 0, d = 0, f = 0, q, v;
	logic        ack_o, ser0, ser1, rtc;
	logic [15:0] ra [4] = '{`GP1_IDX_LATCH_RAW, `GP1_IDX_DIR, `GP1_IDX_FUNC, 16'h0000};
	int          miscompares = 0, n_compared = 0, cycles = 0;
	gp1_port #(.OPEN_DRAIN(OD)) gp1_port_inst (.clk_i(clk_i), .rst_b_i(rst_b_i), .cyc_i(cyc),
		.stb_i(stb), .we_i(we), .adr_i(adr), .sel_i(4'h1), .dat_i(dat), .dat_o(dat_o),
		.ack_o(ack_o), .pin_i(pin_i), .pin_o(pin_o), .pin_oe_b_o(oe_b), .pull_up_o(pu),
		.standby_i(sb), .timer_high_pulse_i(fi[0]), .timer_low_pulse_i(fi[1]),
		.buzzer_i(fi[2]), .ser0_clk_i(fi[5]), .ser0_data_i(fi[6]), .ser0_active_i(fi[7]),
		.ser1_clk_i(fi[3]), .ser1_data_i(fi[4]), .ser1_active_i(fi[8]),
		.ser0_data_in_o(ser0), .ser1_data_in_o(ser1), .realtime_counter_output_ctl_o(rtc));
	gp1_board gp1_board_inst (.clk_i(clk_i), .pin_o(pin_o), .pin_oe_b_o(oe_b),
		.pull_up_o(pu), .ext_en_i(exten), .ext_i(ext), .lvl_o(pin_i));
	always #2 clk_i = ~clk_i;
	always @(posedge clk_i) begin
		cycles++;
		if (cycles == 20000) begin
			miscompares++;
			conclude();
		end
	end
	////////////////////////////////
	function automatic [31:0] nx(input [31:0] s);
		return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
	endfunction
	function automatic [7:0] drv(input [7:0] la, fa, input [8:0] xa);
		logic [7:0] m;
		m = {(xa[0] & xa[2]) ^ la[7], xa[1] ^ la[6], xa[3] | la[5], xa[4] | la[4],
			xa[4] | la[3], xa[5] | la[2], xa[6] | la[1], xa[6] | la[0]};
		return (fa & m) | (~fa & la);
	endfunction
	function automatic [7:0] opx(input [7:0] la, input [2:0] o, b);
		logic [7:0] m;
		m = 8'h01 << b;
		return o == 0 ? la ^ m : o == 1 ? la & ~m : o == 2 ? la | m
			: o == 3 ? la + 8'h01 : o == 4 ? la - 8'h01 : la;
	endfunction
	task cmp(input logic [7:0] g, e);
		n_compared++;
		if (g !== e)
			$display("Error %0t: got %h expected %h", $time, g, e);
		if (g !== e)
			miscompares++;
	endtask
	task wb(input logic w, input logic [15:0] a, dv, output logic [7:0] r);
		{cyc, stb, we, adr, dat} <= {2'b11, w, a, 16'h0000, dv};
		do @(posedge clk_i); while (ack_o !== 1'b1);
		r = dat_o[7:0];
		{cyc, stb} <= 2'b00;
		@(posedge clk_i);
	endtask
	task chk(input logic [7:0] la, da, fa, input logic [8:0] xa);
		logic [7:0] m;
		m = drv(la, fa, xa);
		cmp(oe_b, ~da | (OD & m));
		cmp(pin_o & ~oe_b, m & da & ~OD);
		cmp(pu, ~da & la);
	endtask
	task conclude;
		if (miscompares == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask
	////////////////////////////////
	initial begin
		repeat (20) @(posedge clk_i);
		rst_b_i <= 1;
		@(posedge clk_i);
		foreach (ra[i]) begin
			wb(0, ra[i], 0, q);
			cmp(q, 8'h00);
		end
		wb(1, `GP1_IDX_TEST, 16'h0000, q);
		wb(0, `GP1_IDX_TEST, 0, q);
		cmp(q, `GP1_TST_ONES);
		wb(1, `GP1_IDX_TEST, 16'h0004, q);
		wb(0, `GP1_IDX_TEST, 0, q);
		cmp(q, 8'h7E);
		cmp({7'h00, rtc}, 8'h01);
		repeat (60) begin
			repeat (32) rs = nx(rs);
			sb <= rs[31];
			wb(1, `GP1_IDX_LATCH, rs[7:0], q);
			wb(1, `GP1_IDX_DIR, rs[15:8], q);
			wb(1, `GP1_IDX_FUNC, rs[23:16], q);
			repeat (3) @(posedge clk_i);
			if (sb) chk(l, d, f, x);
			{l, d, f, x} = {rs[7:0], rs[15:8], rs[23:16], rs[31:23]};
			{sb, fi, exten, ext} <= {1'b0, x, ~d, rs[30:23] ^ rs[7:0]};
			repeat (4) @(posedge clk_i);
			chk(l, d, f, x);
			v = drv(l, f, x);
			wb(0, `GP1_IDX_LATCH, 0, q);
			cmp(q & ~(d & OD & v), ((~d & ext) | (d & v)) & ~(d & OD & v));
			wb(1, `GP1_IDX_LATCH_OP, {5'h00, rs[10:8], 5'h00, rs[2:0]}, q);
			l = opx(l, rs[10:8], rs[2:0]);
			wb(0, `GP1_IDX_LATCH_RAW, 0, q);
			cmp(q, l);
			cmp({7'h00, dat_o[`GP1_RAW_ZERO]}, {7'h00, l == 8'h00});
		end
		conclude();
	end
endmodule // tb_gp1_port
`default_nettype wire
